// *** design/spi_ctrl_pkg.sv ***
// Purpose: Shared constants and types of the serial control block.
// Assumes: 20 MHz system clock, 32-bit register port.
// Notes:   Register offsets are byte addresses on the plain port.
package spi_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_TX0  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_TX1  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RX0  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_RX1  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;

	// ----------------------------------------------------------------
	// Control field layout
	// ----------------------------------------------------------------
	localparam int CTRL_LSB = 12;
	localparam int CTRL_MSB = 22;
	localparam int BIT_FLAG = 16;
	localparam int GAP_W    = 4;

	typedef struct packed {
		logic             dual_lane_enable;
		logic             queue_enable;
		logic             byte_reorder;
		logic             inter_byte_sleep;
		logic             slave_role;
		logic             done_irq_enable;
		logic             done_flag;
		logic [GAP_W-1:0] suspend_gap;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = 11'h000;

	// ----------------------------------------------------------------
	// Transfer format
	// ----------------------------------------------------------------
	localparam int                WW_W      = 5;
	localparam logic [WW_W-1:0]   WIDTH_32  = 5'h00;
	localparam logic [5:0]        FULL_BITS = 6'h20;
	localparam logic [2:0]        BYTE_MASK = 3'h7;
	localparam logic [6:0]        SLEEP_ADD = 7'h02;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS            = 50;
	localparam int SCLK_PERIOD_NS    = 400;
	localparam int SCLK_HALF_CYCLES  = SCLK_PERIOD_NS / (2 * CLK_NS);
	localparam int DIV_W             = 8;

	// Pin synchroniser order: {sdi lane 1, sdi lane 0, cs_b, sclk}.
	localparam logic [3:0] PIN_RESET = 4'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_PAUSE
	} eng_state_t;

endpackage

// *** design/spi_ctrl.sv ***
// Operation
// - Master with two lanes drives lane 0 from tx buffer 0, lane 1 from 1.
// - With two lanes, input lane 0 fills rx buffer 0, lane 1 rx buffer 1.
// - Queue enable picks single registers at 0, queued paths at 1.
// - Byte reorder sends and receives least significant byte first.
// - Inter-byte sleep acts only when word width field is zero.
// - Inter-byte sleep pauses suspend gap plus two serial clocks per byte.
// - Role bit 0 selects master, 1 selects slave.
// - Interrupt enable 0 blocks the request, 1 lets it through.
// - Done flag sets when a transfer ends and reads 0 during it.
// - Interrupt request is high while done flag and enable are set.
// - Writing 1 to the done flag clears it.
// - Four-bit suspend gap spaces transactions, master role only.
// - Polarity 0 gap runs last falling edge to next rising edge.
// - Polarity 1 gap runs last rising edge to next falling edge.
// - Suspend gap resets to zero.
//
// Purpose: Serial controller upper control fields with shift engine.
// Assumes: Word width, count and polarity come in as inputs.
// Notes:   Serial pins pass a three-stage synchroniser.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module spi_ctrl #(
	parameter int QDEPTH   = 4,
	parameter int HALF_DIV = spi_ctrl_pkg::SCLK_HALF_CYCLES
) (
	// Clock, reset and enable.
	input  wire logic                            clock_i,
	input  wire logic                            rst_b_i,
	input  wire logic                            ce_i,
	// Register port.
	input  wire logic [spi_ctrl_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [spi_ctrl_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                            wr_i,
	input  wire logic                            rd_i,
	output logic      [spi_ctrl_pkg::DATA_W-1:0] rdata_o,
	// Transfer settings kept elsewhere.
	input  wire logic [spi_ctrl_pkg::WW_W-1:0]   word_width_i,
	input  wire logic [1:0]                      transaction_count_i,
	input  wire logic                            clock_polarity_i,
	input  wire logic                            start_i,
	// Serial link.
	input  wire logic                            sclk_i,
	input  wire logic                            cs_b_i,
	input  wire logic [1:0]                      sdi_i,
	output logic                                 sclk_o,
	output logic                                 sclk_oe_o,
	output logic                                 cs_b_o,
	output logic                                 cs_oe_o,
	output logic      [1:0]                      sdo_o,
	output logic      [1:0]                      sdo_oe_o,
	// Status.
	output logic                                 busy_o,
	output logic                                 irq_o
);
	import spi_ctrl_pkg::*;

	localparam int            PW    = $clog2(QDEPTH);
	localparam logic [PW:0]   QFULL = QDEPTH[PW:0];
	localparam logic [PW:0]   QONE  = {{PW{1'b0}}, 1'b1};
	localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_DIV - 1);

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_b;
	logic [3:0] pin_s1_reg;
	logic [3:0] pin_s2_reg;
	logic [3:0] pin_s3_reg;
	logic [3:0] pin_reg;
	logic [3:0] pin_next;
	logic       slv_sclk_prev_reg;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_reg[1];

	// A bit changes only once the second and third stages agree.
	assign pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) |
	                  (pin_reg & (pin_s2_reg ^ pin_s3_reg));

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_reg        <= PIN_RESET;
			pin_s2_reg        <= PIN_RESET;
			pin_s3_reg        <= PIN_RESET;
			pin_reg           <= PIN_RESET;
			slv_sclk_prev_reg <= 1'b0;
		end else if (ce_i) begin
			pin_s1_reg        <= {sdi_i, cs_b_i, sclk_i};
			pin_s2_reg        <= pin_s1_reg;
			pin_s3_reg        <= pin_s2_reg;
			pin_reg           <= pin_next;
			slv_sclk_prev_reg <= pin_reg[0];
		end
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	ctrl_t ctrl_reg;
	ctrl_t ctrl_next;
	ctrl_t ctrl_wr;
	wire   wr_ctrl = wr_i && (addr_i == OFF_CTRL);
	wire   wr_tx0  = wr_i && (addr_i == OFF_TX0);
	wire   wr_tx1  = wr_i && (addr_i == OFF_TX1);
	wire   rd_rx0  = rd_i && (addr_i == OFF_RX0);
	wire   is_slave = ctrl_reg.slave_role;
	wire   dual     = ctrl_reg.dual_lane_enable;

	// ----------------------------------------------------------------
	// Transmit and receive queues
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] txq0 [QDEPTH];
	logic [DATA_W-1:0] txq1 [QDEPTH];
	logic [DATA_W-1:0] rxq0 [QDEPTH];
	logic [DATA_W-1:0] rxq1 [QDEPTH];
	logic [DATA_W-1:0] tx1_stage_reg;
	logic [PW:0]       tx_wr_reg;
	logic [PW:0]       tx_rd_reg;
	logic [PW:0]       rx_wr_reg;
	logic [PW:0]       rx_rd_reg;
	logic              pop_tx;
	logic              push_rx;
	logic [DATA_W-1:0] rx_word0;
	logic [DATA_W-1:0] rx_word1;

	// Depth one behaves as a plain holding register.
	wire [PW:0] q_limit  = ctrl_reg.queue_enable ? QFULL : QONE;
	wire [PW:0] tx_count = tx_wr_reg - tx_rd_reg;
	wire [PW:0] rx_count = rx_wr_reg - rx_rd_reg;
	wire        tx_full  = (tx_count >= q_limit);
	wire        tx_empty = (tx_count == '0);
	wire        rx_full  = (rx_count >= q_limit);
	wire        rx_empty = (rx_count == '0);
	wire        q_flush  = wr_ctrl &&
	                       (ctrl_wr.queue_enable != ctrl_reg.queue_enable);
	wire        tx_push  = wr_tx0 && !tx_full;
	wire        tx_pop   = pop_tx && !tx_empty;
	wire        rx_push  = push_rx && !rx_full;
	wire        rx_pop   = rd_rx0 && !rx_empty;
	wire [PW-1:0] tx_head = tx_rd_reg[PW-1:0];
	wire [PW-1:0] rx_head = rx_rd_reg[PW-1:0];
	wire [DATA_W-1:0] tx_word0 = tx_empty ? '0 : txq0[tx_head];
	wire [DATA_W-1:0] tx_word1 = tx_empty ? '0 : txq1[tx_head];

	always_ff @(posedge clock_i) begin
		if (ce_i && tx_push) begin
			txq0[tx_wr_reg[PW-1:0]] <= wdata_i;
			txq1[tx_wr_reg[PW-1:0]] <= tx1_stage_reg;
		end
		if (ce_i && rx_push) begin
			rxq0[rx_wr_reg[PW-1:0]] <= rx_word0;
			rxq1[rx_wr_reg[PW-1:0]] <= rx_word1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			tx1_stage_reg <= '0;
			tx_wr_reg     <= '0;
			tx_rd_reg     <= '0;
			rx_wr_reg     <= '0;
			rx_rd_reg     <= '0;
		end else if (ce_i) begin
			if (wr_tx1) tx1_stage_reg <= wdata_i;
			if (q_flush) begin
				tx_wr_reg <= '0;
				tx_rd_reg <= '0;
				rx_wr_reg <= '0;
				rx_rd_reg <= '0;
			end else begin
				if (tx_push) tx_wr_reg <= tx_wr_reg + QONE;
				if (tx_pop)  tx_rd_reg <= tx_rd_reg + QONE;
				if (rx_push) rx_wr_reg <= rx_wr_reg + QONE;
				if (rx_pop)  rx_rd_reg <= rx_rd_reg + QONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] swap_bytes(
		input logic [DATA_W-1:0] w
	);
		swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	eng_state_t        state_reg;
	eng_state_t        state_next;
	logic              sclk_reg;
	logic              sclk_next;
	logic              cs_b_reg;
	logic              cs_b_next;
	logic [DIV_W-1:0]  div_reg;
	logic [5:0]        bit_reg;
	logic [5:0]        bit_next;
	logic [1:0]        txn_reg;
	logic [1:0]        txn_next;
	logic [6:0]        pause_reg;
	logic [6:0]        pause_next;
	logic [DATA_W-1:0] tx_sh0_reg;
	logic [DATA_W-1:0] tx_sh0_next;
	logic [DATA_W-1:0] tx_sh1_reg;
	logic [DATA_W-1:0] tx_sh1_next;
	logic [DATA_W-1:0] rx_sh0_reg;
	logic [DATA_W-1:0] rx_sh0_next;
	logic [DATA_W-1:0] rx_sh1_reg;
	logic [DATA_W-1:0] rx_sh1_next;
	logic              done_evt;
	logic              start_evt;

	wire        is_32     = (word_width_i == WIDTH_32);
	wire [5:0]  bits_tot  = is_32 ? FULL_BITS : {1'b0, word_width_i};
	wire [5:0]  align     = FULL_BITS - bits_tot;
	wire [5:0]  bit_inc   = bit_reg + 6'h01;
	wire        word_end  = (bit_inc == bits_tot);
	wire        byte_end  = ((bit_inc[2:0] & BYTE_MASK) == '0);
	wire        sleep_on  = ctrl_reg.inter_byte_sleep && is_32;
	wire        last_txn  = (txn_reg == transaction_count_i);
	wire [6:0]  gap_ext   = {3'h0, ctrl_reg.suspend_gap};
	// Pause lengths in half serial clock periods.
	wire [6:0]  gap_half  = {gap_ext[5:0], 1'b0};
	wire [6:0]  slp_full  = gap_ext + SLEEP_ADD;
	wire [6:0]  slp_half  = {slp_full[5:0], 1'b0};
	wire        half_tick = (div_reg == HALF_LAST);
	wire        slv_sel   = !pin_reg[1];
	wire        slv_rise  = pin_reg[0] && !slv_sclk_prev_reg;
	wire        slv_fall  = !pin_reg[0] && slv_sclk_prev_reg;
	wire        slv_lead  = slv_sel && (clock_polarity_i ? slv_fall : slv_rise);
	wire        slv_trail = slv_sel && (clock_polarity_i ? slv_rise : slv_fall);
	// Master leading edge leaves the idle level, trailing edge returns.
	wire        mst_lead  = half_tick && (sclk_reg == clock_polarity_i);
	wire        mst_trail = half_tick && (sclk_reg != clock_polarity_i);
	wire        lead      = is_slave ? slv_lead : mst_lead;
	wire        trail     = is_slave ? slv_trail : mst_trail;
	wire [DATA_W-1:0] ld0 = ctrl_reg.byte_reorder ? swap_bytes(tx_word0)
	                                              : tx_word0;
	wire [DATA_W-1:0] ld1 = ctrl_reg.byte_reorder ? swap_bytes(tx_word1)
	                                              : tx_word1;
	wire [DATA_W-1:0] ld0_al = ld0 << align;
	wire [DATA_W-1:0] ld1_al = ld1 << align;
	wire [DATA_W-1:0] rx_mask = ~({DATA_W{1'b1}} << bits_tot);
	wire [DATA_W-1:0] rx0_raw = is_32 ? rx_sh0_reg : (rx_sh0_reg & rx_mask);
	wire [DATA_W-1:0] rx1_raw = is_32 ? rx_sh1_reg : (rx_sh1_reg & rx_mask);

	assign rx_word0 = ctrl_reg.byte_reorder ? swap_bytes(rx0_raw) : rx0_raw;
	assign rx_word1 = !dual ? '0 :
	                  ctrl_reg.byte_reorder ? swap_bytes(rx1_raw) : rx1_raw;

	always_comb begin
		state_next  = state_reg;
		sclk_next   = sclk_reg;
		cs_b_next   = cs_b_reg;
		bit_next    = bit_reg;
		txn_next    = txn_reg;
		pause_next  = pause_reg;
		tx_sh0_next = tx_sh0_reg;
		tx_sh1_next = tx_sh1_reg;
		rx_sh0_next = rx_sh0_reg;
		rx_sh1_next = rx_sh1_reg;
		pop_tx      = 1'b0;
		push_rx     = 1'b0;
		done_evt    = 1'b0;
		start_evt   = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				sclk_next = clock_polarity_i;
				cs_b_next = 1'b1;
				if (start_i) begin
					start_evt   = 1'b1;
					pop_tx      = 1'b1;
					tx_sh0_next = ld0_al;
					tx_sh1_next = ld1_al;
					bit_next    = '0;
					txn_next    = '0;
					cs_b_next   = is_slave;
					state_next  = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (!is_slave && half_tick) sclk_next = !sclk_reg;
				if (lead) begin
					// Agreed value: pin_reg would lag one more clock.
					rx_sh0_next = {rx_sh0_reg[DATA_W-2:0], pin_next[2]};
					rx_sh1_next = {rx_sh1_reg[DATA_W-2:0], pin_next[3]};
				end
				if (trail) begin
					tx_sh0_next = {tx_sh0_reg[DATA_W-2:0], 1'b0};
					tx_sh1_next = {tx_sh1_reg[DATA_W-2:0], 1'b0};
					bit_next    = bit_inc;
					if (word_end) begin
						push_rx  = 1'b1;
						bit_next = '0;
						if (last_txn) begin
							done_evt   = 1'b1;
							cs_b_next  = 1'b1;
							state_next = ST_IDLE;
						end else begin
							pop_tx      = 1'b1;
							tx_sh0_next = ld0_al;
							tx_sh1_next = ld1_al;
							txn_next    = txn_reg + 2'h1;
							pause_next  = gap_half;
							// Gap counted from the trailing edge.
							if (!is_slave && gap_half != '0) begin
								state_next = ST_PAUSE;
							end
						end
					end else if (!is_slave && sleep_on && byte_end) begin
						pause_next = slp_half;
						state_next = ST_PAUSE;
					end
				end
				if (is_slave && !slv_sel && bit_reg != '0) begin
					cs_b_next  = 1'b1;
					state_next = ST_IDLE;
				end
			end
			ST_PAUSE: begin
				if (half_tick) begin
					pause_next = pause_reg - 7'h01;
					if (pause_reg == 7'h01) state_next = ST_SHIFT;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			state_reg  <= ST_IDLE;
			sclk_reg   <= 1'b0;
			cs_b_reg   <= 1'b1;
			div_reg    <= '0;
			bit_reg    <= '0;
			txn_reg    <= '0;
			pause_reg  <= '0;
			tx_sh0_reg <= '0;
			tx_sh1_reg <= '0;
			rx_sh0_reg <= '0;
			rx_sh1_reg <= '0;
		end else if (ce_i) begin
			state_reg  <= state_next;
			sclk_reg   <= sclk_next;
			cs_b_reg   <= cs_b_next;
			div_reg    <= (state_reg == ST_IDLE || half_tick) ? '0
			                                                   : div_reg + 1'b1;
			bit_reg    <= bit_next;
			txn_reg    <= txn_next;
			pause_reg  <= pause_next;
			tx_sh0_reg <= tx_sh0_next;
			tx_sh1_reg <= tx_sh1_next;
			rx_sh0_reg <= rx_sh0_next;
			rx_sh1_reg <= rx_sh1_next;
		end
	end

	// ----------------------------------------------------------------
	// Control register and interrupt
	// ----------------------------------------------------------------
	assign ctrl_wr = ctrl_t'(wdata_i[CTRL_MSB:CTRL_LSB]);

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next           = ctrl_wr;
			ctrl_next.done_flag = ctrl_reg.done_flag &
			                      !wdata_i[BIT_FLAG];
		end
		if (start_evt) ctrl_next.done_flag = 1'b0;
		if (done_evt)  ctrl_next.done_flag = 1'b1;
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= CTRL_RESET;
		end else if (ce_i) begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign irq_o = ctrl_reg.done_flag &&
	               ctrl_reg.done_irq_enable;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	wire [DATA_W-1:0] ctrl_word = {{(DATA_W-1-CTRL_MSB){1'b0}}, ctrl_reg,
	                               {CTRL_LSB{1'b0}}};
	wire [DATA_W-1:0] stat_word = {{(DATA_W-4-2*(PW+1)){1'b0}}, rx_count,
	                               tx_count, rx_empty, tx_full,
	                               (state_reg == ST_PAUSE),
	                               (state_reg != ST_IDLE)};
	wire [DATA_W-1:0] rd_mux =
		(addr_i == OFF_CTRL) ? ctrl_word :
		(addr_i == OFF_TX0)  ? tx_word0 :
		(addr_i == OFF_TX1)  ? tx1_stage_reg :
		(addr_i == OFF_RX0)  ? (rx_empty ? '0 : rxq0[rx_head]) :
		(addr_i == OFF_RX1)  ? (rx_empty ? '0 : rxq1[rx_head]) :
		(addr_i == OFF_STAT) ? stat_word : '0;

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= rd_i ? rd_mux : '0;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	wire slv_drive = is_slave && slv_sel && (state_reg != ST_IDLE);

	assign sclk_o    = sclk_reg;
	assign sclk_oe_o = !is_slave;
	assign cs_b_o    = cs_b_reg;
	assign cs_oe_o   = !is_slave;
	assign sdo_o     = {tx_sh1_reg[DATA_W-1], tx_sh0_reg[DATA_W-1]};
	assign sdo_oe_o  = {(is_slave ? slv_drive : 1'b1) && dual,
	                    is_slave ? slv_drive : 1'b1};
	assign busy_o    = (state_reg != ST_IDLE);

endmodule

// *** bench/spi_ctrl_asserts.sv ***
// Purpose: Port checks of the serial control block.
// Assumes: One clock domain, four clocks per serial half period.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ns
module spi_ctrl_asserts (
	// Clock and reset.
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	// Watched ports.
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        start_i,
	input wire logic        clock_polarity_i,
	input wire logic        sclk_o,
	input wire logic        sclk_oe_o,
	input wire logic        cs_b_o,
	input wire logic        cs_oe_o,
	input wire logic        busy_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_read_quiet: assert property (
		!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside the read answer cycle");
	chk_irq_after: assert property (
		$rose(irq_o) |-> !busy_o)
		else $error("interrupt raised while a transfer runs");
	chk_busy_quiet: assert property (
		busy_o && $past(busy_o) |-> !irq_o)
		else $error("interrupt high during a transfer");
	chk_role_pair: assert property (
		sclk_oe_o == cs_oe_o)
		else $error("clock and select drive disagree");
	chk_cs_start: assert property (
		$rose(busy_o) && sclk_oe_o |-> !cs_b_o)
		else $error("select not low at transfer start");
	chk_start_take: assert property (
		start_i && !busy_o && sclk_oe_o |=> busy_o)
		else $error("start not taken while idle");
	chk_half_len: assert property (
		busy_o && $changed(sclk_o) |=> $stable(sclk_o) [*3])
		else $error("serial clock half period too short");
	chk_idle_level: assert property (
		!busy_o && !$past(busy_o) && $stable(clock_polarity_i)
		&& sclk_oe_o |-> sclk_o == clock_polarity_i)
		else $error("idle serial clock not at polarity level");
	cover property ($rose(irq_o));
	cover property ($fell(cs_b_o));
	cover property (rd_i ##1 rdata_o != 32'h0);
endmodule

bind spi_ctrl spi_ctrl_asserts spi_ctrl_asserts_inst (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .start_i(start_i),
	.clock_polarity_i(clock_polarity_i), .sclk_o(sclk_o),
	.sclk_oe_o(sclk_oe_o), .cs_b_o(cs_b_o), .cs_oe_o(cs_oe_o),
	.busy_o(busy_o), .irq_o(irq_o));

// *** bench/spi_peer.sv ***
// Purpose: Serial peripheral model on the far side of the link.
// Assumes: The controller is master and drives clock and select.
// Notes:   Released lanes show the inverse of their last bit.
`timescale 1ns/1ns
module spi_peer (
	// Link from the controller.
	input  wire logic        sclk_i,
	input  wire logic        cs_b_i,
	input  wire logic [1:0]  sdo_i,
	// Settings and reply words.
	input  wire logic        pol_i,
	input  wire logic [4:0]  width_i,
	input  wire logic [31:0] reply0_i,
	input  wire logic [31:0] reply1_i,
	// Answer lanes and captured words.
	output logic      [1:0]  sdi_o,
	output logic      [31:0] cap0_o,
	output logic      [31:0] cap1_o
);
	logic [31:0] r0   = 32'h0;
	logic [31:0] r1   = 32'h0;
	logic [1:0]  last = 2'h0;
	logic [4:0]  top;
	assign top = width_i - 5'h01;
	assign sdi_o = cs_b_i ? ~last : {r1[top], r0[top]};
	always @(negedge cs_b_i) begin
		r0 = reply0_i;
		r1 = reply1_i;
		cap0_o = 32'h0;
		cap1_o = 32'h0;
	end
	always @(posedge cs_b_i) begin
		last = {r1[top], r0[top]};
	end
	// Leading edges sample, trailing edges shift out the next bit.
	always @(sclk_i) begin
		if (!cs_b_i && sclk_i != pol_i) begin
			cap0_o = {cap0_o[30:0], sdo_i[0]};
			cap1_o = {cap1_o[30:0], sdo_i[1]};
		end else if (!cs_b_i) begin
			r0 = r0 << 1;
			r1 = r1 << 1;
		end
	end
endmodule

// *** bench/spi_ctrl_tb.sv ***
// Purpose: Self-checking bench of the serial control block.
// Assumes: Four clocks per serial half period, queue depth four.
// Notes:   A peer model answers on the serial lanes.
`timescale 1ns/1ns
module spi_ctrl_tb;
	import spi_ctrl_pkg::*;
	localparam int QD = 4;
	localparam int HD = SCLK_HALF_CYCLES;
	logic        clock_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [7:0]  addr_i  = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic        start_i = 1'b0;
	logic        pol     = 1'b0;
	logic [4:0]  width   = 5'h00;
	logic [1:0]  count   = 2'h0;
	logic [31:0] rep0    = 32'h0;
	logic [31:0] rep1    = 32'h0;
	logic [31:0] rdata_o, cap0, cap1, rv;
	logic [1:0]  sdi, sdo_o, sdo_oe_o;
	logic        sclk_o, sclk_oe_o, cs_b_o, cs_oe_o, busy_o, irq_o;
	logic        psc = 1'b0;
	int          n_errors = 0;
	int          n_checks = 0;
	int          run = 0;
	int          mx = 0;
	ctrl_t       c;

	always #25 clock_i = ~clock_i;

	spi_ctrl #(.QDEPTH(QD), .HALF_DIV(HD)) spi_ctrl_inst (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .word_width_i(width),
		.transaction_count_i(count), .clock_polarity_i(pol),
		.start_i(start_i), .sclk_i(1'b0), .cs_b_i(1'b1), .sdi_i(sdi),
		.sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .cs_b_o(cs_b_o),
		.cs_oe_o(cs_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
		.busy_o(busy_o), .irq_o(irq_o));

	spi_peer spi_peer_inst (
		.sclk_i(sclk_o), .cs_b_i(cs_b_o), .sdo_i(sdo_o), .pol_i(pol),
		.width_i(width), .reply0_i(rep0), .reply1_i(rep1),
		.sdi_o(sdi), .cap0_o(cap0), .cap1_o(cap1));

	// Longest stretch of a steady serial clock during a transfer.
	always @(posedge clock_i) begin
		if (start_i) begin
			run <= 0;
			mx <= 0;
		end else if (busy_o && sclk_o !== psc) begin
			run <= 1;
			if (run > mx) mx <= run;
		end else if (busy_o) begin
			run <= run + 1;
		end
		psc <= sclk_o;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		wr_i <= wr;
		rd_i <= !wr;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1 q = rdata_o;
	endtask

	task automatic wrc(input ctrl_t v);
		bus(1'b1, OFF_CTRL, {9'h000, v, 12'h000}, rv);
	endtask

	task automatic rdc();
		bus(1'b0, OFF_CTRL, 32'h0, rv);
	endtask

	task automatic go();
		@(posedge clock_i);
		start_i <= 1'b1;
		@(posedge clock_i);
		start_i <= 1'b0;
		rdc();
		check("flag in flight", 32'(rv[16]), 32'h0);
		for (int i = 0; i < 4000 && busy_o !== 1'b0; i++)
			@(posedge clock_i);
		#1 check("busy end", 32'(busy_o), 32'h0);
	endtask

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_single();
		rdc();
		check("control reset", rv, 32'h0);
		bus(1'b0, 8'h3c, 32'h0, rv);
		check("unmapped", rv, 32'h0);
		c = CTRL_RESET;
		c.done_irq_enable = 1'b1;
		wrc(c);
		@(posedge clock_i);
		width <= 5'h08;
		rep0 <= 32'h3c;
		bus(1'b1, OFF_TX0, 32'ha5, rv);
		go();
		check("lane 0 out", cap0, 32'ha5);
		bus(1'b0, OFF_RX0, 32'h0, rv);
		check("lane 0 in", rv, 32'h3c);
		check("irq on", 32'(irq_o), 32'h1);
		c.done_irq_enable = 1'b0;
		wrc(c);
		rdc();
		check("flag kept", 32'(rv[16]), 32'h1);
		check("irq masked", 32'(irq_o), 32'h0);
		c.done_flag = 1'b1;
		wrc(c);
		rdc();
		check("flag cleared", 32'(rv[16]), 32'h0);
		$display("single transfer test done");
	endtask

	task automatic t_lanes();
		c = CTRL_RESET;
		c.dual_lane_enable = 1'b1;
		wrc(c);
		check("lane 1 drive", 32'(sdo_oe_o), 32'h3);
		@(posedge clock_i);
		count <= 2'h0;
		rep0 <= 32'h0f;
		rep1 <= 32'hf0;
		bus(1'b1, OFF_TX1, 32'h5a, rv);
		bus(1'b1, OFF_TX0, 32'hc3, rv);
		go();
		check("dual lane 0 out", cap0, 32'hc3);
		check("dual lane 1 out", cap1, 32'h5a);
		bus(1'b0, OFF_RX1, 32'h0, rv);
		check("dual lane 1 in", rv, 32'hf0);
		bus(1'b0, OFF_RX0, 32'h0, rv);
		check("dual lane 0 in", rv, 32'h0f);
		c = CTRL_RESET;
		c.byte_reorder = 1'b1;
		wrc(c);
		@(posedge clock_i);
		width <= WIDTH_32;
		rep0 <= 32'ha1b2c3d4;
		bus(1'b1, OFF_TX0, 32'h11223344, rv);
		go();
		check("reorder out", cap0, 32'h44332211);
		bus(1'b0, OFF_RX0, 32'h0, rv);
		check("reorder in", rv, 32'hd4c3b2a1);
		$display("lane and reorder test done");
	endtask

	task automatic t_gaps();
		int sl[4] = '{1, 1, 0, 0};
		int ww[4] = '{0, 8, 8, 8};
		int gp[4] = '{1, 1, 2, 2};
		int tc[4] = '{0, 0, 1, 1};
		int ex[4] = '{(2 * (1 + int'(SLEEP_ADD)) + 1) * HD, HD,
			(2 * 2 + 1) * HD, (2 * 2 + 1) * HD};
		for (int i = 0; i < 4; i++) begin
			c = CTRL_RESET;
			c.inter_byte_sleep = sl[i][0];
			c.suspend_gap = gp[i][3:0];
			wrc(c);
			@(posedge clock_i);
			width <= ww[i][4:0];
			count <= tc[i][1:0];
			pol <= (i == 3);
			repeat (3) @(posedge clock_i);
			go();
			check("hold", 32'(mx), 32'(ex[i]));
		end
		@(posedge clock_i);
		pol <= 1'b0;
		count <= 2'h0;
		$display("pause test done");
	endtask

	task automatic t_queue();
		bus(1'b1, OFF_TX0, 32'h1, rv);
		bus(1'b0, OFF_STAT, 32'h0, rv);
		check("single full", 32'(rv[2]), 32'h1);
		c = CTRL_RESET;
		c.queue_enable = 1'b1;
		wrc(c);
		for (int i = 0; i < QD; i++) begin
			bus(1'b1, OFF_TX0, 32'(i), rv);
			bus(1'b0, OFF_STAT, 32'h0, rv);
			check("queue full", 32'(rv[2]), 32'(i == QD - 1));
		end
		c.slave_role = 1'b1;
		wrc(c);
		@(posedge clock_i);
		#1 check("slave drive", 32'(sclk_oe_o), 32'h0);
		check("slave lanes", 32'(sdo_oe_o), 32'h0);
		c = CTRL_RESET;
		wrc(c);
		@(posedge clock_i);
		#1 check("master drive", 32'(sclk_oe_o), 32'h1);
		$display("queue and role test done");
	endtask

	initial begin
		repeat (5) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_single();
		t_lanes();
		t_gaps();
		t_queue();
		give_verdict();
	end

	initial begin
		#(20000 * CLK_NS);
		n_errors++;
		give_verdict();
	end
endmodule
